// file: logic/bst_map.svh
// constants of the boundary-scan test access port: widths, opcodes, counts
// assumes inclusion by bare name from the package and from the tap module
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

`define BST_IR_W        4
`define BST_DR_W        32
`define BST_IR_IDCODE   4'h1
`define BST_IR_BYPASS   4'hf
`define BST_IR_CAPTURE  4'h1
`define BST_BYP_CAPTURE 1'h0
`define BST_RST_TMS_CNT 3'h5
`define BST_CNT_ONE     3'h1
`define BST_CNT_ZERO    3'h0
`define BST_PIN_IDLE    4'hf
`define BST_TCK_IDLE    1'h1

`endif

// file: logic/bst_pkg.sv
// types of the boundary-scan test access port
// assumes bst_map.svh is on the include path
`default_nettype none
`include "bst_map.svh"

package bst_pkg;

  // sixteen controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } bst_state_t;

  // test pins sampled together from the tester
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_t;

endpackage

`default_nettype wire

// file: logic/bst_tap.sv
// boundary-scan test access port controller with instruction, id and bypass registers
// assumes test pins come asynchronously from an external tester; i_clock is much faster
// than the test clock, which is sampled and edge detected here
`default_nettype none
`include "bst_map.svh"

module bst_tap #(
  parameter logic [`BST_DR_W-1:0] ID_VALUE = 32'h0000_0001 // arbitrary identification value
) (
  input  wire logic i_clock,   // system clock, 50 MHz
  input  wire logic i_rstn,    // system reset, async, active low
  input  wire logic i_tck,     // test clock pin
  input  wire logic i_tms,     // mode select pin
  input  wire logic i_tdi,     // test data in pin
  input  wire logic i_trst_n,  // test reset pin, active low
  output logic      o_tdo,     // test data out
  output logic      o_tdo_oe_n // low while o_tdo is driven
);

  // ********************************************************
  // pin synchronisers and edge detection
  // ********************************************************
  bst_pkg::bst_pins_t pins;
  bst_pkg::bst_pins_t sync1_q;
  bst_pkg::bst_pins_t sync2_q;
  logic               tck_old_q;
  logic               tck_rise;
  logic               tck_fall;
  logic               tap_rst_n;

  assign pins.tck    = i_tck;
  assign pins.tms    = i_tms;
  assign pins.tdi    = i_tdi;
  assign pins.trst_n = i_trst_n;

  // two flops on every pin; the edge detector reads the second only
  // reset to idle pin levels so no false edge or test reset follows reset
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q   <= `BST_PIN_IDLE;
      sync2_q   <= `BST_PIN_IDLE;
      tck_old_q <= `BST_TCK_IDLE;
    end else begin
      sync1_q   <= pins;
      sync2_q   <= sync1_q;
      tck_old_q <= sync2_q.tck;
    end
  end

  assign tck_rise = sync2_q.tck & ~tck_old_q;
  assign tck_fall = ~sync2_q.tck & tck_old_q;

  // test reset acts at once; its release waits for the synchronised copy
  assign tap_rst_n = i_rstn & i_trst_n & sync2_q.trst_n;

  // ********************************************************
  // controller state machine
  // ********************************************************
  bst_pkg::bst_state_t state_q;
  bst_pkg::bst_state_t state_d;
  logic                tms;

  assign tms = sync2_q.tms;

  // next state from mode select on each test clock rise
  always_comb begin
    state_d = state_q;
    if (tck_rise) begin
      unique case (state_q)
        bst_pkg::TEST_LOGIC_RESET: state_d = tms ? bst_pkg::TEST_LOGIC_RESET
                                                 : bst_pkg::RUN_TEST_IDLE;
        bst_pkg::RUN_TEST_IDLE:    state_d = tms ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
        bst_pkg::SELECT_DR:        state_d = tms ? bst_pkg::SELECT_IR : bst_pkg::CAPTURE_DR;
        bst_pkg::CAPTURE_DR:       state_d = tms ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
        bst_pkg::SHIFT_DR:         state_d = tms ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
        bst_pkg::EXIT1_DR:         state_d = tms ? bst_pkg::UPDATE_DR : bst_pkg::PAUSE_DR;
        bst_pkg::PAUSE_DR:         state_d = tms ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
        bst_pkg::EXIT2_DR:         state_d = tms ? bst_pkg::UPDATE_DR : bst_pkg::SHIFT_DR;
        bst_pkg::UPDATE_DR:        state_d = tms ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
        bst_pkg::SELECT_IR:        state_d = tms ? bst_pkg::TEST_LOGIC_RESET : bst_pkg::CAPTURE_IR;
        bst_pkg::CAPTURE_IR:       state_d = tms ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
        bst_pkg::SHIFT_IR:         state_d = tms ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
        bst_pkg::EXIT1_IR:         state_d = tms ? bst_pkg::UPDATE_IR : bst_pkg::PAUSE_IR;
        bst_pkg::PAUSE_IR:         state_d = tms ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
        bst_pkg::EXIT2_IR:         state_d = tms ? bst_pkg::UPDATE_IR : bst_pkg::SHIFT_IR;
        bst_pkg::UPDATE_IR:        state_d = tms ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
      endcase
    end
  end

  // state register; either reset lands in test-logic-reset
  always_ff @(posedge i_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_q <= bst_pkg::TEST_LOGIC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ********************************************************
  // proper-reset tracking
  // ********************************************************
  logic       valid_q;
  logic       valid_d;
  logic [2:0] ones_q;
  logic [2:0] ones_d;

  // a system reset alone does not count as a proper controller reset
  always_comb begin
    ones_d  = ones_q;
    valid_d = valid_q;
    if (tck_rise) begin
      if (!tms) begin
        ones_d = `BST_CNT_ZERO;
      end else if (ones_q != `BST_RST_TMS_CNT) begin
        ones_d = ones_q + `BST_CNT_ONE;
      end
    end
    if (ones_d == `BST_RST_TMS_CNT) begin
      valid_d = 1'b1;
    end
    if (!sync2_q.trst_n) begin
      valid_d = 1'b1;
      ones_d  = `BST_CNT_ZERO;
    end
  end

  // tracking registers, asynchronously cleared only by the system reset
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      valid_q <= 1'b0;
      ones_q  <= `BST_CNT_ZERO;
    end else begin
      valid_q <= valid_d;
      ones_q  <= ones_d;
    end
  end

  // ********************************************************
  // instruction, identification and bypass registers
  // ********************************************************
  logic [`BST_IR_W-1:0] ir_q;
  logic [`BST_IR_W-1:0] ir_d;
  logic [`BST_IR_W-1:0] irs_q;
  logic [`BST_IR_W-1:0] irs_d;
  logic [`BST_DR_W-1:0] drs_q;
  logic [`BST_DR_W-1:0] drs_d;
  logic                 bypass;
  logic                 tdi;

  assign tdi    = sync2_q.tdi;
  assign bypass = (ir_q != `BST_IR_IDCODE);

  // capture, shift and update on test clock rises
  always_comb begin
    ir_d  = ir_q;
    irs_d = irs_q;
    drs_d = drs_q;
    if (state_q == bst_pkg::TEST_LOGIC_RESET) begin
      ir_d = `BST_IR_IDCODE;
    end
    if (tck_rise) begin
      unique case (state_q)
        bst_pkg::CAPTURE_IR: irs_d = `BST_IR_CAPTURE;
        bst_pkg::SHIFT_IR:   irs_d = {tdi, irs_q[`BST_IR_W-1:1]};
        bst_pkg::UPDATE_IR:  ir_d  = irs_q;
        bst_pkg::CAPTURE_DR: drs_d = bypass ? {{(`BST_DR_W-1){1'b0}}, `BST_BYP_CAPTURE} : ID_VALUE;
        bst_pkg::SHIFT_DR: begin
          if (bypass) begin
            drs_d = {{(`BST_DR_W-1){1'b0}}, tdi};
          end else begin
            drs_d = {tdi, drs_q[`BST_DR_W-1:1]};
          end
        end
        default: ;
      endcase
    end
  end

  // shift and instruction registers
  always_ff @(posedge i_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_q  <= `BST_IR_IDCODE;
      irs_q <= '0;
      drs_q <= '0;
    end else begin
      ir_q  <= ir_d;
      irs_q <= irs_d;
      drs_q <= drs_d;
    end
  end

  // ********************************************************
  // test data output
  // ********************************************************
  logic tdo_q;
  logic tdo_d;
  logic oe_n_q;
  logic oe_n_d;
  logic shifting;

  assign shifting = (state_q == bst_pkg::SHIFT_IR) | (state_q == bst_pkg::SHIFT_DR);

  // output and its enable move only on test clock falls
  always_comb begin
    tdo_d  = tdo_q;
    oe_n_d = oe_n_q;
    if (tck_fall) begin
      tdo_d  = (state_q == bst_pkg::SHIFT_IR) ? irs_q[0] : drs_q[0];
      oe_n_d = ~(shifting & valid_q);
    end
    if (!valid_q) begin
      oe_n_d = 1'b1;
    end
  end

  // output flops, undriven from reset
  always_ff @(posedge i_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      tdo_q  <= tdo_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_tdo      = tdo_q;
  assign o_tdo_oe_n = oe_n_q;

endmodule

`default_nettype wire

// file: tb/bst_tap_asserts.sv
// pin timing checks of the test access port
// assumes binding into bst_tap
`default_nettype none
module bst_tap_asserts (
  input wire logic i_clock,   // clock
  input wire logic i_rstn,    // reset
  input wire logic i_tck,     // test clock
  input wire logic i_tms,     // mode
  input wire logic i_tdi,     // data in
  input wire logic i_trst_n,  // test reset
  input wire logic o_tdo,     // data out
  input wire logic o_tdo_oe_n // enable, low on
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // checks
  // ****
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  AST_TRST_OE: assert property (!i_trst_n |-> o_tdo_oe_n)
    else $error("enable in test reset");
  AST_TRST_TDO: assert property (!i_trst_n |-> !o_tdo)
    else $error("data out in test reset");
  AST_RSTN_OFF: assert property ($rose(i_rstn) |-> o_tdo_oe_n [*8])
    else $error("driven before reset");
  AST_TRST_IDLE: assert property ($rose(i_trst_n) |-> o_tdo_oe_n [*8])
    else $error("driven after test reset");
  AST_TDO_FALL: assert property ($changed(o_tdo) && i_trst_n && $past(i_trst_n)
    |-> !$past(i_tck, 3))
    else $error("data out moved off fall");
  AST_OE_FALL: assert property ($fell(o_tdo_oe_n) |-> !$past(i_tck, 3))
    else $error("enable moved off fall");
  AST_TDO_STAND: assert property ((i_tck && i_trst_n) [*6] |-> $stable(o_tdo))
    else $error("data out moved in high phase");
  AST_OE_STAND: assert property ((i_tck && i_trst_n) [*6] |-> $stable(o_tdo_oe_n))
    else $error("enable moved in high phase");
endmodule

bind bst_tap bst_tap_asserts u_asserts (.i_clock(i_clock), .i_rstn(i_rstn), .i_tck(i_tck),
  .i_tms(i_tms), .i_tdi(i_tdi), .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n));
`default_nettype wire

// file: tb/bst_tester.sv
// boundary-scan tester model driving the test pins
// assumes a free-running i_clock; test clock stands high between frames
`default_nettype none
module bst_tester (
  input  wire logic i_clock,  // clock
  input  wire logic i_tdo,    // data out of device
  input  wire logic i_oe_n,   // enable of device
  output logic      o_tck,    // test clock
  output logic      o_tms,    // mode
  output logic      o_tdi,    // data in
  output logic      o_trst_n  // test reset
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // pin driving
  // ****
  // idle levels: clock high between frames, pulled-up inputs high
  initial begin
    o_tck = 1'h1;
    o_tms = 1'h1;
    o_tdi = 1'h1;
    o_trst_n = 1'h1;
  end
  // one test clock: fall with new mode and data, sample, then rise
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    @(posedge i_clock);
    o_tck <= 1'h0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (5) @(posedge i_clock);
    @(negedge i_clock);
    tdo = i_tdo;
    oe_n = i_oe_n;
    @(posedge i_clock);
    o_tck <= 1'h1;
    repeat (5) @(posedge i_clock);
  endtask
  // five mode-high clocks
  task automatic tms_reset();
    logic d;
    logic o;
    repeat (5) step(1'h1, 1'h1, d, o);
  endtask
  // test reset held four clocks
  task automatic pulse_trst();
    @(posedge i_clock);
    o_trst_n <= 1'h0;
    repeat (4) @(posedge i_clock);
    o_trst_n <= 1'h1;
    repeat (4) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the test access port
// assumes bst_tap and the tester model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // bench
  // ****
  localparam logic [31:0] ID = 32'h5a3c_96e1; // arbitrary value
  logic i_clock;
  logic i_rstn;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic oe_n;
  logic t;
  logic e;
  int   errors = 0;
  int   checked = 0;
  bst_tap #(.ID_VALUE(ID)) u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe_n(oe_n));
  bst_tester u_tst (.i_clock(i_clock), .i_tdo(tdo), .i_oe_n(oe_n), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
  // clock
  initial begin
    i_clock = 1'h0;
    forever #10 i_clock = ~i_clock;
  end
  task automatic check(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t bit mismatch", $time);
    end
  endtask
  task automatic st(input logic m, input logic d);
    u_tst.step(m, d, t, e);
  endtask
  task automatic walk(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      st(pat[i], 1'h0);
    end
  endtask
  // no proper reset yet: enable stays off even through shift
  task automatic test_unreset();
    logic [7:0] pat;
    pat = 8'h32;
    for (int i = 0; i < 8; i++) begin
      st(pat[i], 1'h0);
      check(e, 1'h1);
    end
  endtask
  // mode reset, then the id register shifts out
  task automatic test_id();
    u_tst.tms_reset();
    walk(8'h02, 4);
    for (int i = 0; i < 32; i++) begin
      st(i == 31, 1'h1);
      check(e, 1'h0);
      check(t, ID[i]);
    end
    st(1'h1, 1'h0);
    check(e, 1'h1);
    st(1'h0, 1'h0);
  endtask
  // capture of instruction, then bypass delays data by one
  task automatic test_bypass();
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) begin
      st(i == 3, 1'h1);
      check(t, i == 0);
    end
    walk(8'h03, 4);
    st(1'h0, 1'h1);
    check(t, 1'h0);
    st(1'h0, 1'h0);
    check(t, 1'h1);
    st(1'h1, 1'h1);
    check(t, 1'h0);
    check(e, 1'h0);
    walk(8'h01, 2);
  endtask
  // after a system reset, test reset alone validates and the low eight id bits shift out
  task automatic test_trst();
    @(posedge i_clock);
    i_rstn <= 1'h0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'h1;
    u_tst.pulse_trst();
    walk(8'h02, 4);
    for (int i = 0; i < 8; i++) begin
      st(1'h0, 1'h0);
      check(t, ID[i]);
      check(e, 1'h0);
    end
    u_tst.pulse_trst();
    st(1'h0, 1'h0);
    check(e, 1'h1);
  endtask
  task automatic results();
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    i_rstn = 1'h0;
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'h1;
    test_unreset();
    test_id();
    test_bypass();
    test_trst();
    results();
  end
  // watchdog
  initial begin
    #200us;
    errors++;
    results();
  end
endmodule
`default_nettype wire
